/* File: hw/rsq_cfg.svh */
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH
// ==========================================================
// Time base
`define RSQ_CLK_NS 4
`define RSQ_TICK_US 50
`define RSQ_TICK_CYC (`RSQ_TICK_US * 1000 / `RSQ_CLK_NS)
// ==========================================================
// Trigger deglitch and power-good mask window
`define RSQ_DEGL_US 1000
`define RSQ_DEGL_TICKS (`RSQ_DEGL_US / `RSQ_TICK_US)
`define RSQ_MASK_US 5000
`define RSQ_MASK_TICKS (`RSQ_MASK_US / `RSQ_TICK_US)
// ==========================================================
// Power-on delay codes 0..5 in microseconds
`define RSQ_ON_US_0 1000
`define RSQ_ON_US_1 1500
`define RSQ_ON_US_2 2000
`define RSQ_ON_US_3 3000
`define RSQ_ON_US_4 6000
`define RSQ_ON_US_5 11000
// Power-off delay codes 0..5, code 7 follows the on delay
`define RSQ_OFF_US_0 0
`define RSQ_OFF_US_1 500
`define RSQ_OFF_US_2 1000
`define RSQ_OFF_US_3 2000
`define RSQ_OFF_US_4 5000
`define RSQ_OFF_US_5 10000
`define RSQ_OFF_SAME 3'h7
`define RSQ_PRESET_PER_RAIL 3'h7
// Power-good delay choices in microseconds
`define RSQ_PG_US_0 50
`define RSQ_PG_US_1 50000
`define RSQ_PG_US_2 100000
`define RSQ_PG_US_3 200000
// ==========================================================
// Soft-start current steps in mA and step length
`define RSQ_SS_STEP_US 200
`define RSQ_SS_STEP_TICKS (`RSQ_SS_STEP_US / `RSQ_TICK_US)
`define RSQ_B1_LIM1_MA 180
`define RSQ_B1_LIM2_MA 300
`define RSQ_B1_LIM3_MA 720
`define RSQ_B2_LIM1_MA 161
`define RSQ_B2_LIM2_MA 300
`define RSQ_B2_LIM3_MA 536
// ==========================================================
// Register offsets (byte addresses)
`define RSQ_CTRL_OFS 8'h00
`define RSQ_ONDLY_OFS 8'h04
`define RSQ_OFFDLY_OFS 8'h08
`define RSQ_STATUS_OFS 8'h0C
// Control fields and reset values
`define RSQ_CTRL_EN_LSB 0
`define RSQ_CTRL_PRESET_LSB 4
`define RSQ_CTRL_PGSEL_LSB 8
`define RSQ_BUS_EN_RST 4'hF
`define RSQ_PRESET_RST 3'h2
`define RSQ_PGSEL_RST 2'h1
`define RSQ_ONDLY_RST 12'h8D1
`define RSQ_OFFDLY_RST 12'hFFF
`endif

/* File: hw/rsq_pkg.sv */
package rsq_pkg;
  // Power-good delay timer states
  typedef enum logic [2:0] {
    RSQ_PG_IDLE = 3'h1,
    RSQ_PG_COUNT = 3'h2,
    RSQ_PG_DONE = 3'h4
  } rsq_pg_e;
  typedef logic [2:0] rsq_code_t;
endpackage

/* File: hw/rsq_top.sv */
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "rsq_cfg.svh"
// Behaviour
// - Deglitched trigger rising edge starts the power-on sequence.
// - Deglitched trigger falling edge starts the shutdown sequence.
// - Trigger level accepted only after persisting the deglitch time, 1 ms.
// - While trigger is high, rail pin enables have no effect.
// - Rail on = bus enable AND (pin enable OR sequenced trigger).
// - All four bus enable bits reset to on.
// - Rising edge turns each rail on after its own delay, default 1.5/2/3/6 ms.
// - Falling edge turns each rail off after its own delay.
// - On delays selectable 1, 1.5, 2, 3, 6 or 11 ms per rail.
// - Off delays 0, 0.5, 1, 2, 5, 10 ms; default equals on delay.
// - Buck level-ok inputs come from hysteretic 94/85 percent comparators.
// - Power-good delay selectable 50 us, 50, 100, 200 ms; default 50 ms.
// - Enable plus level-ok rise starts counter; reset held low until done.
// - While counting, the other buck's activity is ignored.
// - A level-ok fall after release drives reset low and restarts count.
// - Buck enabled after release starts a 5 ms mask holding reset high.
// - After the mask, reset follows both level-ok signals.
// - Timer cleared by reset and enables, set by enable with level-ok.
// - Supply-ok low disables all four regulators.
// - Soft-start begins only on enable rise with supply already good.
// - Soft-start limits step 180/300/720 mA and 161/300/536 mA.
// - Control port is a slave that never stalls its master.
// - Three-bit preset select picks a per-rail delay combination.
module rsq_top #(
  parameter int TICK_CYC = `RSQ_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic seq_trigger_i,
  input wire logic buck1_pin_enable_i,
  input wire logic buck2_pin_enable_i,
  input wire logic linear1_pin_enable_i,
  input wire logic linear2_pin_enable_i,
  input wire logic buck1_level_ok_i,
  input wire logic buck2_level_ok_i,
  input wire logic supply_ok_i,
  input wire logic power_good_reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic buck1_enable_o,
  output logic buck2_enable_o,
  output logic linear1_enable_o,
  output logic linear2_enable_o,
  output logic [9:0] buck1_ilim_ma_o,
  output logic [9:0] buck2_ilim_ma_o,
  output logic power_good_reset_n_o,
  output logic power_good_reset_n_oe_o
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [4:0] DEGL_TICKS = 5'(`RSQ_DEGL_TICKS);
  localparam logic [6:0] MASK_TICKS = 7'(`RSQ_MASK_TICKS);
  localparam logic [2:0] SS_TICKS = 3'(`RSQ_SS_STEP_TICKS);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] on_ticks(input rsq_pkg::rsq_code_t c);
    case (c)
      3'h0: on_ticks = 8'(`RSQ_ON_US_0 / `RSQ_TICK_US);
      3'h1: on_ticks = 8'(`RSQ_ON_US_1 / `RSQ_TICK_US);
      3'h2: on_ticks = 8'(`RSQ_ON_US_2 / `RSQ_TICK_US);
      3'h3: on_ticks = 8'(`RSQ_ON_US_3 / `RSQ_TICK_US);
      3'h4: on_ticks = 8'(`RSQ_ON_US_4 / `RSQ_TICK_US);
      default: on_ticks = 8'(`RSQ_ON_US_5 / `RSQ_TICK_US);
    endcase
  endfunction

  function automatic logic [7:0] off_ticks(input rsq_pkg::rsq_code_t c);
    case (c)
      3'h0: off_ticks = 8'(`RSQ_OFF_US_0 / `RSQ_TICK_US);
      3'h1: off_ticks = 8'(`RSQ_OFF_US_1 / `RSQ_TICK_US);
      3'h2: off_ticks = 8'(`RSQ_OFF_US_2 / `RSQ_TICK_US);
      3'h3: off_ticks = 8'(`RSQ_OFF_US_3 / `RSQ_TICK_US);
      3'h4: off_ticks = 8'(`RSQ_OFF_US_4 / `RSQ_TICK_US);
      default: off_ticks = 8'(`RSQ_OFF_US_5 / `RSQ_TICK_US);
    endcase
  endfunction

  // Preset table, one code per rail packed LDO2..Buck1
  function automatic logic [11:0] preset_codes(input rsq_pkg::rsq_code_t s);
    case (s)
      3'h0: preset_codes = {3'h0, 3'h0, 3'h0, 3'h0};
      3'h1: preset_codes = {3'h2, 3'h2, 3'h1, 3'h0};
      3'h2: preset_codes = {3'h4, 3'h3, 3'h2, 3'h1};
      3'h3: preset_codes = {3'h0, 3'h0, 3'h2, 3'h1};
      3'h4: preset_codes = {3'h4, 3'h3, 3'h2, 3'h1};
      3'h5: preset_codes = {3'h2, 3'h2, 3'h1, 3'h1};
      3'h6: preset_codes = {3'h1, 3'h0, 3'h2, 3'h3};
      default: preset_codes = 12'h000;
    endcase
  endfunction

  function automatic logic [12:0] pg_ticks(input logic [1:0] s);
    case (s)
      2'h0: pg_ticks = 13'(`RSQ_PG_US_0 / `RSQ_TICK_US);
      2'h1: pg_ticks = 13'(`RSQ_PG_US_1 / `RSQ_TICK_US);
      2'h2: pg_ticks = 13'(`RSQ_PG_US_2 / `RSQ_TICK_US);
      default: pg_ticks = 13'(`RSQ_PG_US_3 / `RSQ_TICK_US);
    endcase
  endfunction

  function automatic logic [9:0] ilim(input logic b2, input logic [1:0] st);
    case (st)
      2'h1: ilim = b2 ? 10'(`RSQ_B2_LIM1_MA) : 10'(`RSQ_B1_LIM1_MA);
      2'h2: ilim = b2 ? 10'(`RSQ_B2_LIM2_MA) : 10'(`RSQ_B1_LIM2_MA);
      2'h3: ilim = b2 ? 10'(`RSQ_B2_LIM3_MA) : 10'(`RSQ_B1_LIM3_MA);
      default: ilim = 10'h000;
    endcase
  endfunction

  // ==========================================================
  // Reset release
  logic rst_meta_q, rst_n;
  // Two stages so the release never lands mid-edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // Time base
  logic [TW-1:0] tick_cnt_q;
  logic tick;
  assign tick = ce_i && (tick_cnt_q == TW'(TICK_CYC - 1));
  // One 50 us tick shared by every timer, so all delays have one-tick jitter
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) tick_cnt_q <= '0;
    else if (ce_i) tick_cnt_q <= tick ? '0 : tick_cnt_q + TW'(1);
  end

  // ==========================================================
  // Registers
  logic [3:0] bus_en_q;
  rsq_pkg::rsq_code_t preset_q;
  logic [1:0] pgsel_q;
  logic [11:0] ondly_q, offdly_q;
  logic [31:0] status;
  // Software writes; unmapped offsets are ignored
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_en_q <= `RSQ_BUS_EN_RST;
      preset_q <= `RSQ_PRESET_RST;
      pgsel_q <= `RSQ_PGSEL_RST;
      ondly_q <= `RSQ_ONDLY_RST;
      offdly_q <= `RSQ_OFFDLY_RST;
    end else if (ce_i && reg_we_i) begin
      case (reg_addr_i)
        `RSQ_CTRL_OFS: begin
          bus_en_q <= reg_wdata_i[`RSQ_CTRL_EN_LSB +: 4];
          preset_q <= reg_wdata_i[`RSQ_CTRL_PRESET_LSB +: 3];
          pgsel_q <= reg_wdata_i[`RSQ_CTRL_PGSEL_LSB +: 2];
        end
        `RSQ_ONDLY_OFS: ondly_q <= reg_wdata_i[11:0];
        `RSQ_OFFDLY_OFS: offdly_q <= reg_wdata_i[11:0];
        default: ;
      endcase
    end
  end

  // Read data valid the cycle after the strobe only; no wait states
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) reg_rdata_o <= '0;
    else if (ce_i) begin
      if (!reg_re_i) reg_rdata_o <= '0;
      else begin
        case (reg_addr_i)
          `RSQ_CTRL_OFS: reg_rdata_o <= {22'h0, pgsel_q, 1'b0, preset_q, bus_en_q};
          `RSQ_ONDLY_OFS: reg_rdata_o <= {20'h0, ondly_q};
          `RSQ_OFFDLY_OFS: reg_rdata_o <= {20'h0, offdly_q};
          `RSQ_STATUS_OFS: reg_rdata_o <= status;
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Trigger deglitch
  logic trig_q, trig_rise, trig_fall;
  logic [4:0] degl_q;
  // A level change must persist for the full window; a bounce restarts it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
      degl_q <= '0;
    end else if (ce_i) begin
      if (seq_trigger_i == trig_q) degl_q <= '0;
      else if (tick) begin
        if (degl_q == DEGL_TICKS - 5'h01) begin
          trig_q <= seq_trigger_i;
          degl_q <= '0;
        end else degl_q <= degl_q + 5'h01;
      end
    end
  end
  assign trig_rise = ce_i && tick && (degl_q == DEGL_TICKS - 5'h01) && seq_trigger_i && !trig_q;
  assign trig_fall = ce_i && tick && (degl_q == DEGL_TICKS - 5'h01) && !seq_trigger_i && trig_q;

  // ==========================================================
  // Per-rail sequencing
  logic [11:0] on_codes;
  logic [3:0] seq_on_q, pend_q, tgt_q;
  logic [7:0] rcnt_q [4];
  assign on_codes = (preset_q == `RSQ_PRESET_PER_RAIL) ? ondly_q : preset_codes(preset_q);

  // Each rail loads its own delay on a trigger edge and flips when it runs out
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_on_q <= '0;
      pend_q <= '0;
      tgt_q <= '0;
      for (int i = 0; i < 4; i++) rcnt_q[i] <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < 4; i++) begin
        if (trig_rise) begin
          pend_q[i] <= 1'b1;
          tgt_q[i] <= 1'b1;
          rcnt_q[i] <= on_ticks(on_codes[3*i +: 3]);
        end else if (trig_fall) begin
          pend_q[i] <= 1'b1;
          tgt_q[i] <= 1'b0;
          if (offdly_q[3*i +: 3] == `RSQ_OFF_SAME)
            rcnt_q[i] <= on_ticks(on_codes[3*i +: 3]);
          else
            rcnt_q[i] <= off_ticks(offdly_q[3*i +: 3]);
        end else if (pend_q[i] && rcnt_q[i] == 8'h00) begin
          seq_on_q[i] <= tgt_q[i];
          pend_q[i] <= 1'b0;
        end else if (pend_q[i] && tick) rcnt_q[i] <= rcnt_q[i] - 8'h01;
      end
    end
  end

  // ==========================================================
  // Regulator enables
  logic [3:0] pins, rail_en_q, rail_en_d;
  assign pins = {linear2_pin_enable_i, linear1_pin_enable_i,
                 buck2_pin_enable_i, buck1_pin_enable_i};
  // Pins are shut out while the trigger is high so the sequence owns the rails
  assign rail_en_d = bus_en_q & {4{supply_ok_i}}
                   & (trig_q ? seq_on_q : (pins | seq_on_q));
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) rail_en_q <= '0;
    else if (ce_i) rail_en_q <= rail_en_d;
  end
  assign buck1_enable_o = rail_en_q[0];
  assign buck2_enable_o = rail_en_q[1];
  assign linear1_enable_o = rail_en_q[2];
  assign linear2_enable_o = rail_en_q[3];

  // ==========================================================
  // Buck soft-start
  logic [1:0] ss_q [2];
  logic [2:0] ss_cnt_q [2];
  logic [1:0] en_prev_q;
  // Rails only rise with supply good, so every rise here is a legal start
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_prev_q <= '0;
      for (int b = 0; b < 2; b++) begin
        ss_q[b] <= '0;
        ss_cnt_q[b] <= '0;
      end
    end else if (ce_i) begin
      en_prev_q <= rail_en_q[1:0];
      for (int b = 0; b < 2; b++) begin
        if (!rail_en_q[b]) ss_q[b] <= 2'h0;
        else if (!en_prev_q[b]) begin
          ss_q[b] <= 2'h1;
          ss_cnt_q[b] <= '0;
        end else if (tick && ss_q[b] != 2'h3) begin
          if (ss_cnt_q[b] == SS_TICKS - 3'h1) begin
            ss_q[b] <= ss_q[b] + 2'h1;
            ss_cnt_q[b] <= '0;
          end else ss_cnt_q[b] <= ss_cnt_q[b] + 3'h1;
        end
      end
    end
  end
  assign buck1_ilim_ma_o = ilim(1'b0, ss_q[0]);
  assign buck2_ilim_ma_o = ilim(1'b1, ss_q[1]);

  // ==========================================================
  // Power-good with delay and mask windows
  rsq_pkg::rsq_pg_e st_q, st_d;
  logic [12:0] pg_cnt_q;
  logic [6:0] mask_q [2];
  logic [1:0] lvl, mask_run, mask_start, term, set_evt;
  logic pg_q, pg_d;
  assign lvl = {buck2_level_ok_i, buck1_level_ok_i};
  assign mask_run = {mask_q[1] != 7'h00, mask_q[0] != 7'h00};
  assign set_evt = rail_en_q[1:0] & lvl;
  // Late enable counts as masked in the cycle before its window is loaded,
  // otherwise the not-yet-ready buck would pull the reset low and restart the delay count
  assign mask_start = (st_q == rsq_pkg::RSQ_PG_DONE) ?
                      (rail_en_q[1:0] & ~en_prev_q) : 2'h0;
  // A masked or disabled buck cannot pull the reset low
  assign term = mask_run | mask_start | ~rail_en_q[1:0] | lvl;

  // Delay timer states
  always_comb begin
    st_d = st_q;
    case (st_q)
      rsq_pkg::RSQ_PG_IDLE: if (set_evt != 2'h0) st_d = rsq_pkg::RSQ_PG_COUNT;
      rsq_pkg::RSQ_PG_COUNT: if (tick && pg_cnt_q == 13'h0001) st_d = rsq_pkg::RSQ_PG_DONE;
      rsq_pkg::RSQ_PG_DONE: if (term != 2'h3) st_d = rsq_pkg::RSQ_PG_COUNT;
      default: st_d = rsq_pkg::RSQ_PG_IDLE;
    endcase
    if (rail_en_q[1:0] == 2'h0) st_d = rsq_pkg::RSQ_PG_IDLE;
  end
  assign pg_d = (st_d == rsq_pkg::RSQ_PG_DONE) && (term == 2'h3);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= rsq_pkg::RSQ_PG_IDLE;
      pg_q <= 1'b0;
      pg_cnt_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
      pg_q <= pg_d;
      // Counting ignores the other buck: no reload until the count ends
      if (st_d == rsq_pkg::RSQ_PG_COUNT && st_q != rsq_pkg::RSQ_PG_COUNT)
        pg_cnt_q <= pg_ticks(pgsel_q);
      else if (st_q == rsq_pkg::RSQ_PG_COUNT && tick) pg_cnt_q <= pg_cnt_q - 13'h0001;
    end
  end

  // Mask window per buck, started by a late enable after release
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) for (int b = 0; b < 2; b++) mask_q[b] <= '0;
    else if (ce_i) begin
      for (int b = 0; b < 2; b++) begin
        if (rail_en_q[b] && !en_prev_q[b] && st_q == rsq_pkg::RSQ_PG_DONE)
          mask_q[b] <= MASK_TICKS;
        else if (tick && mask_q[b] != 7'h00) mask_q[b] <= mask_q[b] - 7'h01;
      end
    end
  end

  // Open-drain reset: only ever drives low
  assign power_good_reset_n_o = 1'b0;
  assign power_good_reset_n_oe_o = !pg_q;
  assign status = {19'h0, mask_run, st_q, supply_ok_i, power_good_reset_n_i,
                   pg_q, trig_q, rail_en_q};

  // ==========================================================
  // Checks
  rise_start_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    trig_rise |=> (pend_q == 4'hF) && (tgt_q == 4'hF))
    else $error("trigger rise did not arm all rails");
  fall_start_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    trig_fall |=> (pend_q == 4'hF) && (tgt_q == 4'h0))
    else $error("trigger fall did not arm shutdown");
  trig_deglitch_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $changed(trig_q) |-> $past(tick) && $past(degl_q) == DEGL_TICKS - 5'h01)
    else $error("trigger accepted before deglitch time");
  pin_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i)
    $past(trig_q) && $past(ce_i) |-> rail_en_q == ($past(bus_en_q)
      & {4{$past(supply_ok_i)}} & $past(seq_on_q)))
    else $error("pin enable leaked through while trigger high");
  uvlo_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i)
    !supply_ok_i |=> rail_en_q == 4'h0)
    else $error("rail enabled with supply low");
  pg_low_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_q != rsq_pkg::RSQ_PG_DONE |-> !pg_q)
    else $error("reset released before delay done");
  sequence s_drop;
    st_q == rsq_pkg::RSQ_PG_DONE && term != 2'h3 && rail_en_q[1:0] != 2'h0 && ce_i;
  endsequence
  pg_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_drop |=> st_q == rsq_pkg::RSQ_PG_COUNT && !pg_q ##0 pg_cnt_q == pg_ticks(pgsel_q))
    else $error("level drop did not restart delay");
  mask_load_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(mask_run[1]) |-> mask_q[1] == MASK_TICKS)
    else $error("mask window wrong length");
  bus_default_a: assert property (@(posedge clk_i)
    $rose(rst_n) |-> bus_en_q == `RSQ_BUS_EN_RST)
    else $error("bus enables not on after reset");
endmodule

/* File: testbench/rsq_host_model.sv */
`timescale 1ns/100ps
// ==========================================
// Far side: buck outputs and the pulled-up reset pin
module rsq_host_model #(
  parameter int RAMP_CYC = 8
) (
  input wire logic clk_i,
  input wire logic [1:0] buck_en_i,
  input wire logic [1:0] dead_i,
  input wire logic rst_oe_i,
  output logic [1:0] level_ok_o,
  output wire logic rst_pin_o
);
  int ramp_q [2];
  // Output ramps after enable; a dead buck never gets there
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (!buck_en_i[i] || dead_i[i]) ramp_q[i] <= 0;
      else if (ramp_q[i] < RAMP_CYC) ramp_q[i] <= ramp_q[i] + 1;
    end
  end
  // Comparator output, drops at once when the buck is cut
  assign level_ok_o = {ramp_q[1] == RAMP_CYC, ramp_q[0] == RAMP_CYC};
  // Open drain with pull-up: released pin reads high
  assign rst_pin_o = rst_oe_i ? 1'b0 : 1'b1;
endmodule

/* File: testbench/rsq_top_bench.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); end end
module rsq_top_bench;
  logic clk = 1'b0, arst_n = 1'b0, trig = 1'b0, sup = 1'b1, we = 1'b0, re = 1'b0;
  logic [3:0] pin = 4'h0, en;
  logic [1:0] dead = 2'h0, lok;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [9:0] il1, il2;
  logic oe, rpin, pgd;
  int mismatches = 0, total_checks = 0;
  // Delay rows per preset code, in 50 us ticks
  int prow [7][4] = '{'{20, 20, 20, 20}, '{20, 30, 40, 40}, '{30, 40, 60, 120},
    '{30, 40, 20, 20}, '{30, 40, 60, 120}, '{30, 30, 40, 40}, '{60, 40, 20, 30}};
  // ==========================================
  // Design and far side; tick shortened to 4 cycles
  rsq_top #(.TICK_CYC(4)) dut_u (.clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1),
    .seq_trigger_i(trig), .buck1_pin_enable_i(pin[0]), .buck2_pin_enable_i(pin[1]),
    .linear1_pin_enable_i(pin[2]), .linear2_pin_enable_i(pin[3]),
    .buck1_level_ok_i(lok[0]), .buck2_level_ok_i(lok[1]), .supply_ok_i(sup),
    .power_good_reset_n_i(rpin), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .buck1_enable_o(en[0]), .buck2_enable_o(en[1]),
    .linear1_enable_o(en[2]), .linear2_enable_o(en[3]), .buck1_ilim_ma_o(il1),
    .buck2_ilim_ma_o(il2), .power_good_reset_n_o(pgd), .power_good_reset_n_oe_o(oe));
  rsq_host_model host_u (.clk_i(clk), .buck_en_i(en[1:0]), .dead_i(dead),
    .rst_oe_i(oe), .level_ok_o(lok), .rst_pin_o(rpin));
  // 250 MHz
  always #2 clk = ~clk;
  // ==========================================
  // Shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata; // Only valid in this one cycle
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait on the reset pin drive
  task automatic wait_oe(input logic lvl, input int lim, output int n);
    n = 0;
    while (oe !== lvl) begin
      cyc(1);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("CHECK FAILED t=%0t timeout exp %0h got %0h", $time, lvl, oe);
        report_and_stop();
      end
    end
  endtask
  // Move trigger, time every rail against its tick count
  task automatic seq(input logic lvl, input int nt[4]);
    int t [4];
    t = '{default: -1};
    @(posedge clk);
    trig <= lvl;
    for (int c = 1; c <= 1200; c++) begin
      cyc(1);
      foreach (t[i]) if (t[i] < 0 && en[i] === lvl) t[i] = c;
    end
    foreach (t[i]) `CHK(t[i] >= (17 + nt[i]) * 4 && t[i] <= (20 + nt[i]) * 4 + 8, 1'b1)
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [7:0] ad [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
    logic [31:0] ex [4] = '{32'h0000012F, 32'h000008D1, 32'h00000FFF, 32'h0};
    `CHK({en, oe}, 5'h01)
    `CHK(pgd, 1'b0)
    foreach (ad[i]) begin
      rd(ad[i], d);
      `CHK(d, ex[i])
    end
    $display("test regs done");
  endtask
  task automatic t_glitch();
    @(posedge clk);
    trig <= 1'b1;
    repeat (60) @(posedge clk);
    trig <= 1'b0;
    cyc(200);
    `CHK(en, 4'h0)
    $display("test glitch done");
  endtask
  task automatic t_pgdef();
    int n;
    logic [31:0] d;
    seq(1'b1, prow[2]);
    wait_oe(1'b0, 5000, n);
    `CHK(n + 1200 >= 4180 && n + 1200 <= 4240, 1'b1)
    @(posedge clk);
    pin <= 4'hF;
    repeat (4) @(posedge clk);
    pin <= 4'h0;
    cyc(4);
    `CHK(en, 4'hF)
    rd(8'h0C, d);
    `CHK(d, 32'h000004FF)
    seq(1'b0, prow[2]);
    `CHK(oe, 1'b1)
    $display("test pgdef done");
  endtask
  task automatic t_presets();
    for (int p = 0; p < 7; p++) begin
      wr(8'h00, 32'h10F | (p << 4));
      seq(1'b1, prow[p]);
      seq(1'b0, prow[p]);
    end
    $display("test presets done");
  endtask
  task automatic t_custom();
    wr(8'h04, 32'h8E8);
    wr(8'h08, 32'h888);
    wr(8'h00, 32'h17F);
    seq(1'b1, '{20, 220, 60, 120});
    seq(1'b0, '{0, 10, 20, 100});
    $display("test custom done");
  endtask
  task automatic t_bus();
    logic [3:0] pat [2] = '{4'hA, 4'h5};
    foreach (pat[i]) begin
      wr(8'h00, 32'h120 | pat[i]);
      pin <= 4'hF;
      cyc(4);
      `CHK(en, pat[i])
      @(posedge clk);
      pin <= 4'h0;
      cyc(4);
      `CHK(en, 4'h0)
    end
    $display("test bus done");
  endtask
  task automatic t_uvlo();
    int at [3] = '{4, 22, 22};
    logic [19:0] ex [3] = '{{10'd180, 10'd161}, {10'd300, 10'd300}, {10'd720, 10'd536}};
    wr(8'h00, 32'h12F);
    pin <= 4'h3;
    foreach (at[i]) begin
      cyc(at[i]);
      `CHK({il1, il2}, ex[i])
    end
    @(posedge clk);
    sup <= 1'b0;
    cyc(2);
    `CHK({en, il1}, 14'h0)
    @(posedge clk);
    sup <= 1'b1;
    cyc(4);
    `CHK({il1, il2}, {10'd180, 10'd161})
    @(posedge clk);
    pin <= 4'h0;
    $display("test uvlo done");
  endtask
  task automatic t_mask();
    int n;
    wr(8'h00, 32'h2F);
    pin <= 4'h1;
    wait_oe(1'b0, 100, n);
    @(posedge clk);
    dead <= 2'b10;
    pin <= 4'h3;
    wait_oe(1'b1, 600, n);
    `CHK(n >= 380 && n <= 420, 1'b1)
    dead <= 2'b00;
    wait_oe(1'b0, 40, n);
    @(posedge clk);
    dead <= 2'b01;
    wait_oe(1'b1, 6, n);
    dead <= 2'b00;
    wait_oe(1'b0, 40, n);
    @(posedge clk);
    pin <= 4'h0;
    $display("test mask done");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    cyc(640); // Supply settle time before first trigger
    t_glitch();
    t_pgdef();
    t_presets();
    t_custom();
    t_bus();
    t_uvlo();
    t_mask();
    report_and_stop();
  end
endmodule
